// File: logic/dlcf_defines.vh
/*
 * Constants for the DAC load, clear and fault control block.
 * Assumes inclusion by bare name from logic/ and verif/ files; definitions only.
 */
`ifndef DLCF_DEFINES_VH
`define DLCF_DEFINES_VH

// ----------------------------------------------------------------------
// Widths and frame layout
// ----------------------------------------------------------------------
`define DLCF_DATA_W      16
`define DLCF_CMD_W       8
`define DLCF_FRAME_W     24
`define DLCF_CNT_W       5
`define DLCF_FRAME_BITS  5'h18

// ----------------------------------------------------------------------
// Commands (upper byte of a frame)
// ----------------------------------------------------------------------
`define DLCF_CMD_INPUT   8'h01
`define DLCF_CMD_CLEAR   8'h02
`define DLCF_CMD_CTRL    8'h03
`define DLCF_CMD_LOAD    8'h04

// ----------------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------------
`define DLCF_CTRL_CLEAR_PIN_ENABLE  0
`define DLCF_CTRL_CLRSW  1
`define DLCF_CTRL_RANGE4 2
`define DLCF_CTRL_VMODE  3
`define DLCF_CTRL_OUTEN  4
`define DLCF_CTRL_W      5
`define DLCF_CTRL_RST    5'h00
`define DLCF_WORD_RST    16'h0000

// ----------------------------------------------------------------------
// Zero-scale codes
// ----------------------------------------------------------------------
`define DLCF_ZERO_CODE   16'h0000
`define DLCF_FOUR_MA     16'h3333

`endif

// File: logic/dlcf_sync2.v
/*
 * Two flip-flop synchroniser, one bit.
 * Assumes the input is asynchronous to clk; reset is synchronous active low.
 */
`timescale 1ns/100ps
module dlcf_sync2 (
    // Clock and reset
    input  wire clk,
    input  wire rst_b,
    input  wire rst_val,
    // Data
    input  wire async_in,
    output wire sync_out
);
    reg meta_ff;
    reg sync_ff;

    always @(posedge clk) begin
        if (!rst_b) begin
            meta_ff <= rst_val;
            sync_ff <= rst_val;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule // dlcf_sync2

// File: logic/dlcf_ctrl.v
/*
 * Digital control around one DAC channel: serial shift register, input,
 * DAC, clear and control registers, load and clear pins, fault output.
 * Assumes all pins are asynchronous to clk, and that clk is well above
 * twice the serial clock rate.
 */
// How it works
// [R1] Load pin low copies the input register into the DAC register at once.
// [R2] Fault pin is pulled low on open current output, shorted voltage output, or clear held.
// [R3] Serial data out changes only after a falling serial clock edge.
// [R4] Serial data out is released while chip select is high.
// [R5] Serial data out shows the shift register contents for readback or chaining.
// [R6] Clear held forces the DAC code to the clear value or to zero scale.
// [R7] Clear register is written over the serial port and kept for every clear.
// [R8] Clear pin forces the DAC code only while the clear-pin enable bit is set; it pulls the fault pin low regardless.
// [R9] Serial data in is shifted on each rising serial clock edge.
// [R10] Serial activity is ignored while chip select is high.
// [R11] After reset outputs are off and the shift, input, clear, DAC and control registers are zero.
// [R12] Serial writes land in the input register; only a load moves them on.
`timescale 1ns/100ps
`include "dlcf_defines.vh"
module dlcf_ctrl (
    // Clock and reset
    input  wire                     clk,
    input  wire                     rst_b,
    // Serial port
    input  wire                     sclk,
    input  wire                     cs_n,
    input  wire                     din,
    output reg                      dout_o_ff,
    output reg                      dout_oe_ff,
    // Load and clear pins
    input  wire                     load_update_n,
    input  wire                     clear_n,
    // Analog status
    input  wire                     current_output_open,
    input  wire                     voltage_output_short,
    // Fault open-drain pin
    output reg                      fault_o_ff,
    output reg                      fault_oe_ff,
    // Converter side
    output reg [`DLCF_DATA_W-1:0]   dac_code_ff,
    output reg                      voltage_output_en_ff,
    output reg                      current_output_en_ff,
    output reg                      clear_active_ff
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    wire sclk_s;
    wire cs_n_s;
    wire din_s;
    wire load_n_s;
    wire clr_n_s;
    wire open_s;
    wire short_s;

    // Each synchroniser resets to the idle level of its pin, so no false edge follows reset.
    dlcf_sync2 u_sync_sclk (.clk(clk), .rst_b(rst_b), .rst_val(1'b0),
                            .async_in(sclk), .sync_out(sclk_s));
    dlcf_sync2 u_sync_cs   (.clk(clk), .rst_b(rst_b), .rst_val(1'b1),
                            .async_in(cs_n), .sync_out(cs_n_s));
    dlcf_sync2 u_sync_din  (.clk(clk), .rst_b(rst_b), .rst_val(1'b0),
                            .async_in(din), .sync_out(din_s));
    dlcf_sync2 u_sync_ld   (.clk(clk), .rst_b(rst_b), .rst_val(1'b1),
                            .async_in(load_update_n), .sync_out(load_n_s));
    dlcf_sync2 u_sync_clr  (.clk(clk), .rst_b(rst_b), .rst_val(1'b1),
                            .async_in(clear_n), .sync_out(clr_n_s));
    dlcf_sync2 u_sync_open (.clk(clk), .rst_b(rst_b), .rst_val(1'b0),
                            .async_in(current_output_open), .sync_out(open_s));
    dlcf_sync2 u_sync_shrt (.clk(clk), .rst_b(rst_b), .rst_val(1'b0),
                            .async_in(voltage_output_short), .sync_out(short_s));

    // ------------------------------------------------------------------
    // Edge detection on synchronised serial clock and chip select
    // ------------------------------------------------------------------
    reg sclk_d_ff;
    reg cs_d_ff;
    always @(posedge clk) begin
        if (!rst_b) begin
            sclk_d_ff <= 1'b0;
            cs_d_ff   <= 1'b1;
        end else begin
            sclk_d_ff <= sclk_s;
            cs_d_ff   <= cs_n_s;
        end
    end

    wire sclk_rise = sclk_s & ~sclk_d_ff & ~cs_n_s; // [R10]
    wire sclk_fall = ~sclk_s & sclk_d_ff & ~cs_n_s; // [R10]
    // A frame ends when chip select rises; only then is the word acted on.
    wire frame_end = cs_n_s & ~cs_d_ff;

    // ------------------------------------------------------------------
    // Shift register
    // ------------------------------------------------------------------
    reg [`DLCF_FRAME_W-1:0] shift_ff;
    reg [`DLCF_CNT_W-1:0]   bits_ff;

    always @(posedge clk) begin
        if (!rst_b) begin
            shift_ff <= {`DLCF_FRAME_W{1'b0}};        // [R11]
            bits_ff  <= {`DLCF_CNT_W{1'b0}};
        end else if (sclk_rise) begin
            shift_ff <= {shift_ff[`DLCF_FRAME_W-2:0], din_s}; // [R9]
            if (bits_ff != `DLCF_FRAME_BITS)
                bits_ff <= bits_ff + 5'h01;
        end else if (frame_end) begin
            bits_ff <= {`DLCF_CNT_W{1'b0}};
        end
    end

    // Output follows the MSB, updated only on falling serial clock so the
    // host sees stable data at its rising sample edge.
    always @(posedge clk) begin
        if (!rst_b) begin
            dout_o_ff  <= 1'b0;
            dout_oe_ff <= 1'b0;                       // [R11]
        end else begin
            dout_oe_ff <= ~cs_n_s;                    // [R4]
            if (sclk_fall)
                dout_o_ff <= shift_ff[`DLCF_FRAME_W-1]; // [R3] [R5]
        end
    end

    // ------------------------------------------------------------------
    // Command decode and registers
    // ------------------------------------------------------------------
    wire                     frame_ok = frame_end & (bits_ff == `DLCF_FRAME_BITS);
    wire [`DLCF_CMD_W-1:0]   cmd      = shift_ff[`DLCF_FRAME_W-1:`DLCF_DATA_W];
    wire [`DLCF_DATA_W-1:0]  payload  = shift_ff[`DLCF_DATA_W-1:0];

    reg [`DLCF_DATA_W-1:0]   input_reg_ff;
    reg [`DLCF_DATA_W-1:0]   clear_reg_ff;
    reg [`DLCF_DATA_W-1:0]   dac_reg_ff;
    reg [`DLCF_CTRL_W-1:0]   ctrl_ff;

    wire clear_on = ~clr_n_s & ctrl_ff[`DLCF_CTRL_CLEAR_PIN_ENABLE]; // [R8]
    wire load_pin = ~load_n_s;
    wire load_cmd = frame_ok & (cmd == `DLCF_CMD_LOAD);

    always @(posedge clk) begin
        if (!rst_b) begin
            input_reg_ff <= `DLCF_WORD_RST;           // [R11]
            clear_reg_ff <= `DLCF_WORD_RST;
            dac_reg_ff   <= `DLCF_WORD_RST;
            ctrl_ff      <= `DLCF_CTRL_RST;
        end else begin
            if (frame_ok && cmd == `DLCF_CMD_INPUT)
                input_reg_ff <= payload;              // [R12]
            if (frame_ok && cmd == `DLCF_CMD_CLEAR)
                clear_reg_ff <= payload;              // [R7]
            if (frame_ok && cmd == `DLCF_CMD_CTRL)
                ctrl_ff <= payload[`DLCF_CTRL_W-1:0];
            if (load_pin || load_cmd)
                dac_reg_ff <= input_reg_ff;           // [R1] [R12]
        end
    end

    // ------------------------------------------------------------------
    // Output code, fault and enables
    // ------------------------------------------------------------------
    reg [`DLCF_DATA_W-1:0] nxt_code;
    always @* begin
        nxt_code = dac_reg_ff;
        if (load_pin)
            nxt_code = input_reg_ff;                  // [R1]
        if (clear_on) begin
            if (ctrl_ff[`DLCF_CTRL_CLRSW])
                nxt_code = clear_reg_ff;              // [R6]
            else if (!ctrl_ff[`DLCF_CTRL_VMODE] && ctrl_ff[`DLCF_CTRL_RANGE4])
                nxt_code = `DLCF_FOUR_MA;             // [R6]
            else
                nxt_code = `DLCF_ZERO_CODE;           // [R6]
        end
    end

    wire out_en = ctrl_ff[`DLCF_CTRL_OUTEN];
    wire fault  = (open_s & current_output_en_ff) |
                  (short_s & voltage_output_en_ff) | ~clr_n_s;

    always @(posedge clk) begin
        if (!rst_b) begin
            dac_code_ff          <= `DLCF_ZERO_CODE;  // [R11]
            voltage_output_en_ff <= 1'b0;
            current_output_en_ff <= 1'b0;
            clear_active_ff      <= 1'b0;
            fault_o_ff           <= 1'b0;
            fault_oe_ff          <= 1'b0;
        end else begin
            dac_code_ff          <= nxt_code;
            voltage_output_en_ff <= out_en & ctrl_ff[`DLCF_CTRL_VMODE];
            current_output_en_ff <= out_en & ~ctrl_ff[`DLCF_CTRL_VMODE];
            clear_active_ff      <= clear_on;
            fault_o_ff           <= 1'b0;
            fault_oe_ff          <= fault;            // [R2]
        end
    end
endmodule // dlcf_ctrl

// File: verif/dlcf_chk.sv
/* Checker on the pins of dlcf_ctrl: serial output, fault pin and DAC code.
   Assumes clk runs well above twice the serial clock; bound at the foot. */
`timescale 1ns/100ps
`include "dlcf_defines.vh"
module dlcf_chk (
    // Clock and reset
    input logic                    clk,
    input logic                    rst_b,
    // Pins
    input logic                    sclk,
    input logic                    cs_n,
    input logic                    load_update_n,
    input logic                    clear_n,
    input logic                    current_output_open,
    input logic                    voltage_output_short,
    // Outputs
    input logic                    dout_o_ff,
    input logic                    dout_oe_ff,
    input logic                    fault_o_ff,
    input logic                    fault_oe_ff,
    input logic [`DLCF_DATA_W-1:0] dac_code_ff,
    input logic                    voltage_output_en_ff,
    input logic                    current_output_en_ff,
    input logic                    clear_active_ff
);
    // Short pin histories cover the synchroniser lag of three to five edges.
    reg  [5:0] sck_h;
    reg  [5:0] ev_h;
    reg        cs_q;
    reg        clr_q;
    wire       fell = |(sck_h[5:1] & ~sck_h[4:0]);
    wire       ev   = ~load_update_n | ~clear_n | (cs_n & ~cs_q) | (clear_n & ~clr_q);
    always @(posedge clk) begin
        sck_h <= {sck_h[4:0], sclk};
        ev_h  <= {ev_h[4:0], ev};
        cs_q  <= cs_n;
        clr_q <= clear_n;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_hiz; cs_n [*5] |-> !dout_oe_ff; endproperty
    a_hiz: assert property (p_hiz) else $error("dout driven while deselected");
    property p_drv; !cs_n [*5] |-> dout_oe_ff; endproperty
    a_drv: assert property (p_drv) else $error("dout not driven while selected");
    property p_fall; $changed(dout_o_ff) |-> fell; endproperty
    a_fall: assert property (p_fall) else $error("dout moved without falling sclk");
    property p_od; !fault_o_ff; endproperty
    a_od: assert property (p_od) else $error("fault pin driven high");
    property p_fclr; !clear_n [*5] |-> fault_oe_ff; endproperty
    a_fclr: assert property (p_fclr) else $error("fault missing with clear low");
    property p_fidle;
        (clear_n && !current_output_open && !voltage_output_short) [*5] |-> !fault_oe_ff;
    endproperty
    a_fidle: assert property (p_fidle) else $error("fault without cause");
    property p_fout;
        ((current_output_open && current_output_en_ff) ||
         (voltage_output_short && voltage_output_en_ff)) [*5] |-> fault_oe_ff;
    endproperty
    a_fout: assert property (p_fout) else $error("output fault not flagged");
    property p_dac; $changed(dac_code_ff) |-> |ev_h; endproperty
    a_dac: assert property (p_dac) else $error("DAC code moved without load");
    property p_clroff; clear_n [*5] |-> !clear_active_ff; endproperty
    a_clroff: assert property (p_clroff) else $error("clear forcing with pin high");
endmodule // dlcf_chk

bind dlcf_ctrl dlcf_chk dlcf_chk_inst (
    .clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_n(cs_n), .load_update_n(load_update_n),
    .clear_n(clear_n), .current_output_open(current_output_open),
    .voltage_output_short(voltage_output_short), .dout_o_ff(dout_o_ff),
    .dout_oe_ff(dout_oe_ff), .fault_o_ff(fault_o_ff), .fault_oe_ff(fault_oe_ff),
    .dac_code_ff(dac_code_ff), .voltage_output_en_ff(voltage_output_en_ff),
    .current_output_en_ff(current_output_en_ff), .clear_active_ff(clear_active_ff));

// File: verif/dlcf_host.sv
/* Serial host model: sends 24-bit frames MSB first and reads dout back.
   Assumes the bench calls xfer; lines move on falling clk edges. */
`timescale 1ns/100ps
module dlcf_host (
    // Clock and serial lines
    input  logic clk,
    input  logic dout,
    output logic sclk,
    output logic cs_n,
    output logic din
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b0;
    end
    // Half period of four clk gives the 400 ns serial clock; sclk rests low.
    task automatic xfer(input logic [23:0] tx, input logic cs_hi, output logic [23:0] rx);
        int i;
        @(negedge clk);
        cs_n = cs_hi;
        repeat (4) @(negedge clk);
        for (i = 23; i >= 0; i--) begin
            din = tx[i];
            repeat (4) @(negedge clk);
            sclk = 1'b1;
            repeat (4) @(negedge clk);
            rx   = {rx[22:0], dout};
            sclk = 1'b0;
        end
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        din  = ~din;
        repeat (4) @(negedge clk);
    endtask
endmodule // dlcf_host

// File: verif/tb_top.sv
/* Self-checking bench for dlcf_ctrl with the serial host model.
   Assumes a 50 ns clk; all pins change on falling clk edges. */
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0, rst_b = 1'b0, load_update_n = 1'b1, clear_n = 1'b1;
    logic current_output_open = 1'b0, voltage_output_short = 1'b0;
    logic sclk, cs_n, din, dout_o_ff, dout_oe_ff, fault_o_ff, fault_oe_ff, clear_active_ff;
    logic voltage_output_en_ff, current_output_en_ff;
    logic [15:0] dac_code_ff;
    logic [23:0] rx_word;
    int          err_total = 0, n_tests = 0, cyc = 0;
    // No pull on the data line: a released line shows the inverse, so late sampling shows up.
    wire         dout_w = dout_oe_ff ? dout_o_ff : ~dout_o_ff;
    dlcf_ctrl dlcf_ctrl_inst (.clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout_o_ff(dout_o_ff), .dout_oe_ff(dout_oe_ff), .load_update_n(load_update_n),
        .clear_n(clear_n), .current_output_open(current_output_open),
        .voltage_output_short(voltage_output_short), .fault_o_ff(fault_o_ff),
        .fault_oe_ff(fault_oe_ff), .dac_code_ff(dac_code_ff),
        .voltage_output_en_ff(voltage_output_en_ff),
        .current_output_en_ff(current_output_en_ff), .clear_active_ff(clear_active_ff));
    dlcf_host dlcf_host_inst (.clk(clk), .dout(dout_w), .sclk(sclk), .cs_n(cs_n), .din(din));
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic send(input logic [7:0] cmd, input logic [15:0] val);
        dlcf_host_inst.xfer({cmd, val}, 1'b0, rx_word);
        repeat (2) @(negedge clk);
    endtask
    task automatic t_load;
        send(8'h01, 16'ha5c3);
        chk(24'(dac_code_ff), 24'h0);
        dlcf_host_inst.xfer(24'h01ffff, 1'b1, rx_word);
        load_update_n = 1'b0;
        repeat (4) @(negedge clk);
        chk(24'(dac_code_ff), 24'h00a5c3);
        load_update_n = 1'b1;
        send(8'h01, 16'h1234);
        // The first bit read is left over from the frame before; the rest is the old word.
        chk(24'(rx_word[22:0]), 24'h01a5c3);
        send(8'h04, 16'h0000);
        chk(24'(dac_code_ff), 24'h001234);
    endtask
    task automatic t_clear;
        logic [4:0]  cv [5] = '{5'h1b, 5'h1a, 5'h15, 5'h11, 5'h1d};
        logic [15:0] cd [5] = '{16'h0f0f, 16'h1234, 16'h3333, 16'h0000, 16'h0000};
        int          i;
        send(8'h02, 16'h0f0f);
        for (i = 0; i < 5; i++) begin
            send(8'h03, {11'h0, cv[i]});
            clear_n = 1'b0;
            repeat (5) @(negedge clk);
            chk(24'(dac_code_ff), 24'(cd[i]));
            chk(24'({fault_oe_ff, clear_active_ff}), {22'h0, 1'b1, cv[i][0]});
            clear_n = 1'b1;
            repeat (5) @(negedge clk);
            chk(24'(dac_code_ff), 24'h001234);
        end
    endtask
    task automatic t_fault;
        voltage_output_short = 1'b1;
        repeat (5) @(negedge clk);
        chk(24'({fault_oe_ff, voltage_output_en_ff}), 24'h3);
        voltage_output_short = 1'b0;
        current_output_open  = 1'b1;
        send(8'h03, 16'h0011);
        chk(24'({fault_oe_ff, current_output_en_ff}), 24'h3);
        current_output_open = 1'b0;
        repeat (5) @(negedge clk);
        chk(24'(fault_oe_ff), 24'h0);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        chk(24'({dac_code_ff, fault_oe_ff, dout_oe_ff, fault_o_ff, clear_active_ff}), 24'h0);
        chk(24'({voltage_output_en_ff, current_output_en_ff}), 24'h0);
        @(negedge clk);
        chk(24'({dac_code_ff, fault_oe_ff, dout_oe_ff, fault_o_ff, clear_active_ff}), 24'h0);
        repeat (2) @(negedge clk);
        t_load();
        t_clear();
        t_fault();
        stop_test();
    end
endmodule // tb_top
